// ===== src/tsr_consts.svh
`ifndef TSR_CONSTS_SVH
`define TSR_CONSTS_SVH

// command codes that select a register
`define TSR_CMD_TEMP 8'h00
`define TSR_CMD_CFG 8'h01

// configuration field positions
`define TSR_CFG_STBY_BIT 7
`define TSR_CFG_RDY_BIT 6

// power-up values
`define TSR_TEMP_RST 8'h00
`define TSR_CFG_RST 8'h00
`define TSR_PTR_RST 8'h00

// saturation limits of the temperature code
`define TSR_TEMP_MAX 8'h7f
`define TSR_TEMP_MIN 8'h80

`endif

// ===== src/tsr_pkg.sv
package tsr_pkg;

  // one request from the serial slave engine; strobes are one-cycle pulses
  typedef struct packed {
    logic cmd_wr;
    logic data_wr;
    logic data_rd;
    logic [7:0] wbyte;
  } tsr_req_s;

  typedef struct packed {
    logic standby_switch;
    logic data_ready;
    logic [5:0] resv;
  } tsr_cfg_s;

endpackage

// ===== src/tsr_regs.sv
// Summary of operation
// - command 00h selects the temperature register
// - command 01h selects configuration for read/write
// - configuration bit 7: standby switch, resets zero
// - configuration bit 6: read-only conversion done flag
// - configuration bits 5..0 always read zero
// - done flag cleared at reset and standby
// - each conversion outside standby loads two's complement temperature
// - data registers update automatically, alternately
// - one count equals one degree Celsius
// - zero is 0 C, negatives two's complement
// - temperature register 8-bit, read-only, resets zero
// - temperature loads together with done flag rising
// - all registers 8 bits, configuration resets zero
// - standby halts converter, freezes data, port runs
// - receive byte reads last selected register
`timescale 1ns/1ps
`default_nettype none
`include "tsr_consts.svh"

module tsr_regs #(
  parameter int CONV_W = 13,
  parameter int CONV_FRAC = 4
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire tsr_pkg::tsr_req_s i_req,
  input wire logic i_conv_done,
  input wire logic signed [CONV_W-1:0] i_conv_raw,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  output logic o_standby,
  output logic o_data_ready
);
  import tsr_pkg::*;

  logic [7:0] ptr_ff;
  logic [7:0] nxt_ptr;
  logic stby_ff;
  logic nxt_stby;
  logic rdy_ff;
  logic nxt_rdy;
  logic [7:0] bank_ff [2];
  logic [7:0] nxt_bank [2];
  logic sel_ff;
  logic nxt_sel;
  logic [7:0] rd_data_ff;
  logic [7:0] nxt_rd_data;
  logic rd_valid_ff;
  logic nxt_rd_valid;
  logic [7:0] temp_round;
  logic [7:0] temp_cur;
  logic cfg_wr;
  logic conv_take;

  // read image of whichever register the pointer names
  function automatic logic [7:0] reg_image(input logic [7:0] ptr,
                                           input logic [7:0] temp,
                                           input logic stby,
                                           input logic rdy);
    tsr_cfg_s cfg;
    cfg = '0;
    cfg.standby_switch = stby;
    cfg.data_ready = rdy;
    cfg.resv = 6'h00;
    case (ptr)
      `TSR_CMD_TEMP: reg_image = temp;
      `TSR_CMD_CFG: reg_image = cfg;
      default: reg_image = 8'h00;
    endcase
  endfunction

  tsr_round #(
    .W(CONV_W),
    .FRAC(CONV_FRAC)
  ) u_round (
    .i_raw(i_conv_raw),
    .o_deg(temp_round)
  );

  assign temp_cur = bank_ff[sel_ff];
  assign cfg_wr = i_req.data_wr && (ptr_ff == `TSR_CMD_CFG);
  // a conversion landing while standby is set is dropped, not deferred
  assign conv_take = i_conv_done && !stby_ff;

  always_comb begin
    nxt_ptr = ptr_ff;
    nxt_stby = stby_ff;
    nxt_rdy = rdy_ff;
    nxt_bank = bank_ff;
    nxt_sel = sel_ff;
    nxt_rd_valid = i_req.data_rd;
    nxt_rd_data = rd_data_ff;
    // data strobes use the pointer from before any same-cycle command
    if (i_req.cmd_wr) begin
      nxt_ptr = i_req.wbyte;
    end
    if (cfg_wr) begin
      nxt_stby = i_req.wbyte[`TSR_CFG_STBY_BIT];
    end
    // temperature writes fall through untouched
    if (nxt_stby) begin
      nxt_rdy = 1'b0;
    end else if (conv_take) begin
      nxt_rdy = 1'b1;
      nxt_sel = ~sel_ff;
      nxt_bank[~sel_ff] = temp_round;
    end
    if (i_req.data_rd) begin
      nxt_rd_data = reg_image(ptr_ff, temp_cur, stby_ff, rdy_ff);
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ptr_ff <= `TSR_PTR_RST;
      stby_ff <= 1'b0;
      rdy_ff <= 1'b0;
      bank_ff[0] <= `TSR_TEMP_RST;
      bank_ff[1] <= `TSR_TEMP_RST;
      sel_ff <= 1'b0;
      rd_data_ff <= 8'h00;
      rd_valid_ff <= 1'b0;
    end else if (i_ce) begin
      ptr_ff <= nxt_ptr;
      stby_ff <= nxt_stby;
      rdy_ff <= nxt_rdy;
      bank_ff <= nxt_bank;
      sel_ff <= nxt_sel;
      rd_data_ff <= nxt_rd_data;
      rd_valid_ff <= nxt_rd_valid;
    end
  end

  assign o_rd_data = rd_data_ff;
  assign o_rd_valid = rd_valid_ff;
  assign o_standby = stby_ff;
  assign o_data_ready = rdy_ff;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  sequence s_sel_temp;
    i_ce && i_req.cmd_wr && i_req.wbyte == `TSR_CMD_TEMP;
  endsequence

  sequence s_sel_cfg;
    i_ce && i_req.cmd_wr && i_req.wbyte == `TSR_CMD_CFG;
  endsequence

  sequence s_read;
    i_ce && i_req.data_rd && !i_req.cmd_wr;
  endsequence

  sequence s_conv;
    i_ce && conv_take && !(cfg_wr && i_req.wbyte[`TSR_CFG_STBY_BIT]);
  endsequence

  temp_read_a: assert property (
    s_sel_temp ##1 s_read |=> o_rd_valid && o_rd_data == $past(temp_cur))
    else $error("temperature read mismatch");

  cfg_read_a: assert property (
    s_sel_cfg ##1 s_read |=>
      o_rd_valid && o_rd_data == {$past(stby_ff), $past(rdy_ff), 6'h00})
    else $error("configuration read mismatch");

  stby_write_a: assert property (
    i_ce && cfg_wr |=> stby_ff == $past(i_req.wbyte[`TSR_CFG_STBY_BIT]))
    else $error("standby switch not written");

  rdy_readonly_a: assert property (
    i_ce && cfg_wr && !i_req.wbyte[`TSR_CFG_STBY_BIT] && !i_conv_done
      |=> rdy_ff == $past(rdy_ff))
    else $error("done flag changed by a write");

  resv_zero_a: assert property (
    s_sel_cfg ##1 s_read |=> o_rd_data[5:0] == 6'h00)
    else $error("reserved bits not zero");

  stby_clears_a: assert property (
    stby_ff |-> !rdy_ff)
    else $error("done flag set in standby");

  conv_load_a: assert property (
    s_conv |=> rdy_ff && temp_cur == $past(temp_round)
      && sel_ff != $past(sel_ff))
    else $error("conversion not loaded");

  round_sat_a: assert property (
    (i_conv_raw >>> CONV_FRAC) > 127 |-> temp_round == `TSR_TEMP_MAX)
    else $error("no saturation at top");

  temp_hold_a: assert property (
    i_ce && i_req.data_wr && ptr_ff == `TSR_CMD_TEMP && !conv_take
      |=> temp_cur == $past(temp_cur))
    else $error("temperature changed by a write");

  stby_freeze_a: assert property (
    stby_ff ##1 stby_ff [*2] |-> temp_cur == $past(temp_cur, 2))
    else $error("data moved in standby");

  ptr_keep_a: assert property (
    i_ce && !i_req.cmd_wr |=> ptr_ff == $past(ptr_ff))
    else $error("pointer moved without command");

  rd_pulse_a: assert property (
    i_ce |=> o_rd_valid == $past(i_req.data_rd))
    else $error("read valid not a one-cycle answer");

  ce_hold_a: assert property (
    !i_ce |=> ptr_ff == $past(ptr_ff) && stby_ff == $past(stby_ff)
      && rdy_ff == $past(rdy_ff) && temp_cur == $past(temp_cur))
    else $error("state moved with clock enable low");
endmodule // tsr_regs

`default_nettype wire

// ===== src/tsr_round.sv
`timescale 1ns/1ps
`default_nettype none
`include "tsr_consts.svh"

// converts a fixed-point reading to whole degrees; FRAC must be at least 1
module tsr_round #(
  parameter int W = 13,
  parameter int FRAC = 4
) (
  input wire logic signed [W-1:0] i_raw,
  output logic [7:0] o_deg
);
  localparam logic signed [W:0] HALF = (W+1)'(1) <<< (FRAC - 1);
  localparam logic signed [W:0] MAXV = (W+1)'(127);
  localparam logic signed [W:0] MINV = -(W+1)'(128);

  logic signed [W:0] sum;
  logic signed [W:0] whole;

  // adding one half then flooring sends exact halves toward positive
  always_comb begin
    sum = $signed({i_raw[W-1], i_raw}) + HALF;
    whole = sum >>> FRAC;
    if (whole > MAXV) begin
      o_deg = `TSR_TEMP_MAX;
    end else if (whole < MINV) begin
      o_deg = `TSR_TEMP_MIN;
    end else begin
      o_deg = whole[7:0];
    end
  end
endmodule // tsr_round

`default_nettype wire

// ===== tb/thermal_sensor_register_set_bench.sv
`timescale 1ns/1ps
`default_nettype none

module thermal_sensor_register_set_bench;
  import tsr_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic i_conv_done = 1'b0;
  logic ce = 1'b1;
  logic signed [12:0] i_conv_raw = '0;
  tsr_req_s req;
  logic [7:0] o_rd_data;
  logic o_rd_valid;
  logic o_standby;
  logic o_data_ready;
  int err_total = 0;
  int check_count = 0;

  always #5 i_clk_sys = ~i_clk_sys;

  tsr_host host (.i_clk_sys(i_clk_sys), .o_req(req));
  tsr_regs uut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(ce),
    .i_req(req), .i_conv_done(i_conv_done), .i_conv_raw(i_conv_raw),
    .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
    .o_standby(o_standby), .o_data_ready(o_data_ready));

  task automatic chk(input string what, input logic [7:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rd(input logic [7:0] exp);
    host.send(3'b001, 8'h00);
    chk("rd_valid", o_rd_valid, 8'h01);
    chk("rd_data", o_rd_data, exp);
  endtask

  task automatic conv(input int deg16);
    @(negedge i_clk_sys);
    i_conv_done = 1'b1;
    i_conv_raw = 13'(deg16);
    @(negedge i_clk_sys);
    i_conv_done = 1'b0;
    i_conv_raw = ~i_conv_raw;
  endtask

  task automatic t_reset();
    chk("standby", o_standby, 8'h00);
    chk("ready", o_data_ready, 8'h00);
    rd(8'h00);
    host.send(3'b100, 8'h01);
    rd(8'h00);
    $display("t_reset done");
  endtask

  // raw readings in 1/16 degree; reads without a new command byte
  task automatic t_round();
    int raw[10] = '{404, 8, 4, -4, -8, -12, -876, 2024, 2080, -3200};
    logic [7:0] exp[10] = '{8'h19, 8'h01, 8'h00, 8'h00, 8'h00, 8'hff,
      8'hc9, 8'h7f, 8'h7f, 8'h80};
    host.send(3'b100, 8'h00);
    foreach (raw[i]) begin
      conv(raw[i]);
      chk("ready", o_data_ready, 8'h01);
      rd(exp[i]);
    end
    $display("t_round done");
  endtask

  task automatic t_cfg();
    host.send(3'b100, 8'h01);
    host.send(3'b010, 8'hff);
    chk("standby", o_standby, 8'h01);
    chk("ready", o_data_ready, 8'h00);
    rd(8'h80);
    conv(16);
    chk("ready", o_data_ready, 8'h00);
    host.send(3'b100, 8'h00);
    rd(8'h80);
    host.send(3'b100, 8'h01);
    host.send(3'b010, 8'h40);
    rd(8'h00);
    conv(48);
    host.send(3'b010, 8'h00);
    rd(8'h40);
    host.send(3'b100, 8'h00);
    rd(8'h03);
    $display("t_cfg done");
  endtask

  task automatic t_wr();
    host.send(3'b010, 8'h55);
    rd(8'h03);
    host.send(3'b100, 8'h02);
    rd(8'h00);
    $display("t_wr done");
  endtask

  // clock enable low freezes every flop, the read strobe included
  task automatic t_ce();
    host.send(3'b100, 8'h01);
    @(negedge i_clk_sys);
    ce = 1'b0;
    host.send(3'b010, 8'h80);
    conv(160);
    host.send(3'b001, 8'h00);
    chk("rd_valid_ce", o_rd_valid, 8'h00);
    chk("standby_ce", o_standby, 8'h00);
    chk("ready_ce", o_data_ready, 8'h01);
    ce = 1'b1;
    rd(8'h40);
    host.send(3'b100, 8'h00);
    rd(8'h03);
    $display("t_ce done");
  endtask

  // command byte straight followed by a read uses the new pointer;
  // a read in the same cycle as a command still uses the old one
  task automatic t_b2b();
    host.pair(3'b100, 8'h01, 3'b001, 8'h00);
    chk("rd_valid_b2b", o_rd_valid, 8'h01);
    chk("cfg_b2b", o_rd_data, 8'h40);
    host.pair(3'b100, 8'h00, 3'b001, 8'h00);
    chk("temp_b2b", o_rd_data, 8'h03);
    host.send(3'b101, 8'h01);
    chk("old_ptr", o_rd_data, 8'h03);
    rd(8'h40);
    $display("t_b2b done");
  endtask

  // a second reset in mid-run brings back the power-up state
  task automatic t_rst();
    @(negedge i_clk_sys);
    i_rst = 1'b1;
    repeat (2) @(negedge i_clk_sys);
    i_rst = 1'b0;
    chk("ready_rst", o_data_ready, 8'h00);
    chk("standby_rst", o_standby, 8'h00);
    rd(8'h00);
    $display("t_rst done");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(negedge i_clk_sys);
    i_rst = 1'b0;
    t_reset();
    t_round();
    t_cfg();
    t_wr();
    t_ce();
    t_b2b();
    t_rst();
    results();
  end

  // the tests need well under 1000 cycles
  initial begin
    #200000;
    err_total++;
    results();
  end
endmodule // thermal_sensor_register_set_bench

`default_nettype wire

// ===== tb/tsr_host.sv
`timescale 1ns/1ps
`default_nettype none

// host controller side: one byte-level request per send call, two per pair call
module tsr_host (
  input wire logic i_clk_sys,
  output tsr_pkg::tsr_req_s o_req
);
  import tsr_pkg::*;

  initial o_req = '0;

  // kind is {cmd_wr, data_wr, data_rd}: command byte then data byte
  // the pointer byte picks the register for later data
  task automatic send(input logic [2:0] kind, input logic [7:0] b);
    @(negedge i_clk_sys);
    o_req = {kind, b};
    @(negedge i_clk_sys);
    // released byte lane shows garbage, not the last value
    o_req = {3'b000, ~b};
  endtask

  // two requests on consecutive edges, no idle cycle between
  task automatic pair(input logic [2:0] k1, input logic [7:0] b1,
                      input logic [2:0] k2, input logic [7:0] b2);
    @(negedge i_clk_sys);
    o_req = {k1, b1};
    @(negedge i_clk_sys);
    o_req = {k2, b2};
    @(negedge i_clk_sys);
    o_req = {3'b000, ~b2};
  endtask
endmodule // tsr_host

`default_nettype wire
